// ==== hdl/itw_sync.sv ====
// Purpose: Loader and bus-side coordination for an isochronous transmit DMA.
// Assumes: Shared FIFO outside; fifo_full_i keeps one spare slot.
// Notes:   Summary of operation below.
// Summary of operation
// - On start, write two end-of-cycle tokens before any cycle is loaded.
// - On start, loader_slot becomes current cycle plus three.
// - Without pending drops, begin a pass only when latest cycle start is at least loader_slot minus two.
// - Any pending drop starts a pass at once, whatever the cycle number.
// - drop_mode changes only between passes and rules the whole pass.
// - Each pass starts slot_walker at zero and visits every context.
// - Cycle-match evaluation runs per context even in skipped passes.
// - Each active context loads one packet or is skipped; empty cycles load nothing.
// - A packet is written until complete, then command pointer takes pkt_next_ptr_i.
// - Skip replaces command pointer with skip address of current descriptor.
// - Pass end increments loader_slot; loaded pass also writes one token.
// - A skipped pass writes no packet and no token.
// - A skipped pass decrements pending_drops atomically.
// - A cycle loss never ends a pass or flushes the FIFO.
// - On start, bus_side_slot becomes current cycle plus one.
// - Wait for cycle start of bus_side_slot before transmitting from FIFO.
// - After a finished or lost cycle, increment bus_side_slot and wait again.
// - Two timer rollovers without a cycle start declare a cycle loss.
// - A loss adds one to pending_drops, then waits for the next cycle.
// - Exactly one token consumed per cycle not lost; none for lost cycles.
// - Optional fast loss: subaction gap after one rollover counts as loss.
// - A token at FIFO head is popped, bus_side_slot steps, wait resumes.
// - FIFO empty when arbitration is won means a cycle loss.
`timescale 1ns/1ps
`default_nettype none
module itw_sync (
  // Clock and reset
  input  wire logic                        core_clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        clk_en_i,
  // Control
  input  wire logic                        start_i,
  input  wire logic                        fast_loss_en_i,
  // Cycle timer and bus events
  input  wire logic [itw_pkg::CYC_W-1:0]   cycle_num_i,
  input  wire logic                        cyc_start_i,
  input  wire logic [itw_pkg::CYC_W-1:0]   cyc_start_num_i,
  input  wire logic                        timer_roll_i,
  input  wire logic                        subaction_gap_i,
  input  wire logic                        iso_period_i,
  input  wire logic                        arb_won_i,
  // Context pointer loading
  input  wire logic                        ptr_load_i,
  input  wire logic [itw_pkg::CTX_W-1:0]   ptr_load_ctx_i,
  input  wire logic [itw_pkg::ADDR_W-1:0]  ptr_load_val_i,
  // Cycle-match evaluation
  output logic                             cm_req_o,
  output logic      [itw_pkg::CTX_W-1:0]   cm_ctx_o,
  output logic      [itw_pkg::CYC_W-1:0]   cm_cycle_o,
  output logic      [itw_pkg::ADDR_W-1:0]  cm_ptr_o,
  input  wire logic                        cm_done_i,
  input  wire logic                        cm_active_i,
  input  wire logic                        cm_empty_i,
  // Descriptor skip-address read
  output logic                             desc_req_o,
  input  wire logic                        desc_ack_i,
  input  wire logic [itw_pkg::ADDR_W-1:0]  desc_skip_i,
  // Packet fetch stream
  output logic                             pkt_req_o,
  output logic                             pkt_ready_o,
  input  wire logic                        pkt_valid_i,
  input  wire logic [itw_pkg::DATA_W-1:0]  pkt_data_i,
  input  wire logic                        pkt_last_i,
  input  wire logic [itw_pkg::ADDR_W-1:0]  pkt_next_ptr_i,
  // FIFO write side
  output logic                             fifo_wr_o,
  output logic      [itw_pkg::DATA_W-1:0]  fifo_data_o,
  output logic                             fifo_tok_o,
  input  wire logic                        fifo_full_i,
  // FIFO read side and transmitter
  input  wire logic                        fifo_empty_i,
  input  wire logic                        fifo_tok_head_i,
  output logic                             fifo_pop_o,
  output logic                             tx_go_o,
  input  wire logic                        tx_done_i,
  // Status
  output logic                             loss_o,
  output logic      [itw_pkg::DROP_W-1:0]  drops_o
);
  import itw_pkg::*;

  // ----------------------------------------------------------------
  // Modular cycle arithmetic
  // ----------------------------------------------------------------
  function automatic logic [CYC_W-1:0] cyc_add(input logic [CYC_W-1:0] a,
                                               input logic [CYC_W-1:0] k);
    logic [CYC_W:0] s;
    s = {1'b0, a} + {1'b0, k};
    if (s >= {1'b0, CYC_MOD}) begin
      s = s - {1'b0, CYC_MOD};
    end
    return s[CYC_W-1:0];
  endfunction

  // True when a is at or after b on the wrapping cycle circle
  function automatic logic cyc_ge(input logic [CYC_W-1:0] a, input logic [CYC_W-1:0] b);
    return cyc_add(a, CYC_MOD - b) < CYC_HALF;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  itw_dstate_t             d_st_r;
  itw_lstate_t             l_st_r;
  logic [CYC_W-1:0]        loader_slot_r;
  logic [CYC_W-1:0]        bus_side_slot_r;
  logic [CYC_W-1:0]        last_cs_r;
  logic [CTX_W-1:0]        slot_walker_r;
  logic                    drop_mode_r;
  logic [1:0]              prime_cnt_r;
  logic [1:0]              roll_cnt_r;
  logic [DROP_W-1:0]       pending_drops_r;
  logic [ADDR_W-1:0]       cmd_ptr_r [NCTX];

  logic                    start_go;
  logic                    ws_ok;
  logic                    pkt_take;
  logic                    tok_wr;
  logic                    eoc_go;
  logic                    skip_done;
  logic                    cs_hit;
  logic                    roll_loss;
  logic                    loss_now;

  assign start_go  = clk_en_i && start_i && (d_st_r == D_IDLE);
  assign ws_ok     = cyc_ge(last_cs_r, cyc_add(loader_slot_r, CYC_MOD - WORKAHEAD));
  assign pkt_take  = pkt_valid_i && pkt_ready_o && (d_st_r == D_LOAD);
  assign tok_wr    = !fifo_full_i && (d_st_r == D_PRIME || (d_st_r == D_EOC && !drop_mode_r));
  assign eoc_go    = (d_st_r == D_EOC) && (drop_mode_r || !fifo_full_i);
  assign skip_done = clk_en_i && eoc_go && drop_mode_r;
  assign cs_hit    = cyc_start_i && (cyc_start_num_i == bus_side_slot_r);
  assign roll_loss = (timer_roll_i && roll_cnt_r == LOSS_ROLLS - 2'h1) ||
                     (fast_loss_en_i && subaction_gap_i && roll_cnt_r != 2'h0);

  // ----------------------------------------------------------------
  // Loader side sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      d_st_r        <= D_IDLE;
      prime_cnt_r   <= 2'h0;
      slot_walker_r <= '0;
      drop_mode_r   <= 1'b0;
    end else if (clk_en_i) begin
      case (d_st_r)
        D_IDLE: begin
          if (start_i) begin
            prime_cnt_r <= PRIME_TOKENS;
            d_st_r      <= D_PRIME;
          end
        end
        D_PRIME: begin
          if (tok_wr) begin
            prime_cnt_r <= prime_cnt_r - 2'h1;
            if (prime_cnt_r == 2'h1) begin
              d_st_r <= D_GATE;
            end
          end
        end
        D_GATE: begin
          if (pending_drops_r != DROP_RST) begin
            drop_mode_r   <= 1'b1;
            slot_walker_r <= '0;
            d_st_r        <= D_MATCH;
          end else if (ws_ok) begin
            drop_mode_r   <= 1'b0;
            slot_walker_r <= '0;
            d_st_r        <= D_MATCH;
          end
        end
        D_MATCH: d_st_r <= D_MWAIT;
        D_MWAIT: begin
          if (cm_done_i) begin
            if (!cm_active_i || cm_empty_i) begin
              d_st_r <= D_NEXT;
            end else if (drop_mode_r) begin
              d_st_r <= D_SKIP;
            end else begin
              d_st_r <= D_LOAD;
            end
          end
        end
        D_LOAD: begin
          if (pkt_take && pkt_last_i) begin
            d_st_r <= D_NEXT;
          end
        end
        D_SKIP: begin
          if (desc_ack_i) begin
            d_st_r <= D_NEXT;
          end
        end
        D_NEXT: begin
          if (slot_walker_r == CTX_W'(NCTX - 1)) begin
            d_st_r <= D_EOC;
          end else begin
            slot_walker_r <= slot_walker_r + 1'b1;
            d_st_r        <= D_MATCH;
          end
        end
        D_EOC: begin
          if (eoc_go) begin
            d_st_r <= D_GATE;
          end
        end
        default: d_st_r <= D_IDLE;
      endcase
    end
  end

  // Target cycle of the loader
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      loader_slot_r <= SLOT_RST;
    end else if (start_go) begin
      loader_slot_r <= cyc_add(cycle_num_i, LOADER_LEAD);
    end else if (clk_en_i && eoc_go) begin
      loader_slot_r <= cyc_add(loader_slot_r, ONE_CYC);
    end
  end

  // Latest cycle start seen on the bus, seeded at start
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_cs_r <= SLOT_RST;
    end else if (start_go) begin
      last_cs_r <= cycle_num_i;
    end else if (clk_en_i && cyc_start_i) begin
      last_cs_r <= cyc_start_num_i;
    end
  end

  // Per-context command pointers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NCTX; i++) begin
        cmd_ptr_r[i] <= PTR_RST;
      end
    end else if (clk_en_i) begin
      if (d_st_r == D_SKIP && desc_ack_i) begin
        cmd_ptr_r[slot_walker_r] <= desc_skip_i;
      end else if (pkt_take && pkt_last_i) begin
        cmd_ptr_r[slot_walker_r] <= pkt_next_ptr_i;
      end else if (ptr_load_i) begin
        cmd_ptr_r[ptr_load_ctx_i] <= ptr_load_val_i;
      end
    end
  end

  // Requests to match logic, descriptor reader and packet fetch
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cm_req_o    <= 1'b0;
      cm_ctx_o    <= '0;
      cm_cycle_o  <= SLOT_RST;
      cm_ptr_o    <= PTR_RST;
      desc_req_o  <= 1'b0;
      pkt_req_o   <= 1'b0;
      pkt_ready_o <= 1'b0;
    end else if (clk_en_i) begin
      cm_req_o    <= (d_st_r == D_MATCH);
      cm_ctx_o    <= slot_walker_r;
      cm_cycle_o  <= loader_slot_r;
      cm_ptr_o    <= cmd_ptr_r[slot_walker_r];
      desc_req_o  <= (d_st_r == D_MWAIT) && cm_done_i && cm_active_i && !cm_empty_i &&
                     drop_mode_r;
      pkt_req_o   <= (d_st_r == D_MWAIT) && cm_done_i && cm_active_i && !cm_empty_i &&
                     !drop_mode_r;
      pkt_ready_o <= !fifo_full_i && !(pkt_take && pkt_last_i) &&
                     ((d_st_r == D_LOAD) || pkt_req_o);
    end
  end

  // FIFO writes: packet words and end-of-cycle tokens
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fifo_wr_o   <= 1'b0;
      fifo_tok_o  <= 1'b0;
      fifo_data_o <= '0;
    end else if (clk_en_i) begin
      fifo_wr_o   <= pkt_take || tok_wr;
      fifo_tok_o  <= tok_wr;
      fifo_data_o <= pkt_take ? pkt_data_i : '0;
    end
  end

  // ----------------------------------------------------------------
  // Bus side sequencing
  // ----------------------------------------------------------------
  always_comb begin
    loss_now = 1'b0;
    if (clk_en_i) begin
      case (l_st_r)
        L_WAIT:  loss_now = !cs_hit && roll_loss;
        L_HEAD:  loss_now = !fifo_tok_head_i && !iso_period_i;
        L_ARB:   loss_now = arb_won_i ? fifo_empty_i : (!iso_period_i || roll_loss);
        default: loss_now = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      l_st_r          <= L_IDLE;
      bus_side_slot_r <= SLOT_RST;
      roll_cnt_r      <= 2'h0;
    end else if (clk_en_i) begin
      if (loss_now) begin
        bus_side_slot_r <= cyc_add(bus_side_slot_r, ONE_CYC);
        roll_cnt_r      <= 2'h0;
        l_st_r          <= L_WAIT;
      end else begin
        if (timer_roll_i && roll_cnt_r != LOSS_ROLLS) begin
          roll_cnt_r <= roll_cnt_r + 2'h1;
        end
        case (l_st_r)
          L_IDLE: begin
            if (start_i && d_st_r == D_IDLE) begin
              bus_side_slot_r <= cyc_add(cycle_num_i, BUS_LEAD);
              roll_cnt_r      <= 2'h0;
              l_st_r          <= L_WAIT;
            end
          end
          L_WAIT: begin
            if (cs_hit) begin
              roll_cnt_r <= 2'h0;
              l_st_r     <= L_HEAD;
            end
          end
          L_HEAD: begin
            if (fifo_tok_head_i) begin
              bus_side_slot_r <= cyc_add(bus_side_slot_r, ONE_CYC);
              roll_cnt_r      <= 2'h0;
              l_st_r          <= L_WAIT;
            end else begin
              roll_cnt_r <= 2'h0;
              l_st_r     <= L_ARB;
            end
          end
          L_ARB: begin
            if (arb_won_i) begin
              l_st_r <= L_TX;
            end
          end
          L_TX: begin
            if (tx_done_i) begin
              l_st_r <= L_HEAD;
            end
          end
          default: l_st_r <= L_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fifo_pop_o <= 1'b0;
      tx_go_o    <= 1'b0;
      loss_o     <= 1'b0;
    end else if (clk_en_i) begin
      fifo_pop_o <= (l_st_r == L_HEAD) && fifo_tok_head_i;
      tx_go_o    <= (l_st_r == L_ARB) && arb_won_i && !fifo_empty_i;
      loss_o     <= loss_now;
    end
  end

  // Shared lost-cycle count; simultaneous add and remove cancel
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pending_drops_r <= DROP_RST;
    end else if (loss_now && !skip_done && pending_drops_r != DROP_MAX) begin
      pending_drops_r <= pending_drops_r + 1'b1;
    end else if (skip_done && !loss_now && pending_drops_r != DROP_RST) begin
      pending_drops_r <= pending_drops_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drops_o <= DROP_RST;
    end else if (clk_en_i) begin
      drops_o <= pending_drops_r;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_head_tok;
    clk_en_i && l_st_r == L_HEAD && fifo_tok_head_i && !loss_now;
  endsequence

  a_loader_init: assert property (start_go |=>
    loader_slot_r == cyc_add($past(cycle_num_i), LOADER_LEAD))
    else $error("loader slot not current cycle plus three");
  a_bus_init: assert property (start_go && l_st_r == L_IDLE |=>
    bus_side_slot_r == cyc_add($past(cycle_num_i), BUS_LEAD))
    else $error("bus slot not current cycle plus one");
  a_prime_tokens: assert property (start_go ##1 (fifo_full_i == 1'b0)[*2] |->
    fifo_wr_o && fifo_tok_o ##1 fifo_wr_o && fifo_tok_o)
    else $error("two start tokens not written");
  a_gate_hold: assert property (clk_en_i && d_st_r == D_GATE &&
    pending_drops_r == DROP_RST && !ws_ok |=> d_st_r == D_GATE)
    else $error("pass started beyond workahead");
  a_drop_enter: assert property (clk_en_i && d_st_r == D_GATE &&
    pending_drops_r != DROP_RST |=> d_st_r == D_MATCH && drop_mode_r)
    else $error("pending drop did not start skip pass");
  a_skip_silent: assert property (drop_mode_r && $past(drop_mode_r) |-> !fifo_wr_o)
    else $error("skipped pass wrote to fifo");
  a_drop_dec: assert property (skip_done && !loss_now &&
    pending_drops_r != DROP_RST |=> pending_drops_r == $past(pending_drops_r) - 1'b1)
    else $error("skip pass did not decrement drops");
  a_slot_step: assert property (clk_en_i && eoc_go |=>
    loader_slot_r == cyc_add($past(loader_slot_r), ONE_CYC))
    else $error("loader slot did not step");
  a_roll_loss: assert property (clk_en_i && l_st_r == L_WAIT && !cs_hit &&
    timer_roll_i && roll_cnt_r == 2'h1 |=> loss_o ##1 !loss_o)
    else $error("second rollover not reported as loss");
  a_token_pop: assert property (s_head_tok |=> fifo_pop_o && l_st_r == L_WAIT)
    else $error("head token not consumed");
  a_empty_arb: assert property (clk_en_i && l_st_r == L_ARB && arb_won_i &&
    fifo_empty_i |=> loss_o && !tx_go_o)
    else $error("empty fifo at arbitration not a loss");

endmodule
`default_nettype wire

// ==== include/itw_pkg.sv ====
// Purpose: Shared constants and state types for the isochronous transmit workahead sync.
// Assumes: Cycle numbers count modulo CYC_MOD.
// Notes:   State codes are one-hot.
package itw_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int          CYC_W    = 13;
  localparam int          NCTX     = 4;
  localparam int          CTX_W    = 2;
  localparam int          DATA_W   = 32;
  localparam int          ADDR_W   = 32;
  localparam int          DROP_W   = 4;

  // ----------------------------------------------------------------
  // Cycle arithmetic and counts
  // ----------------------------------------------------------------
  localparam logic [CYC_W-1:0]  CYC_MOD      = 13'h1f40;
  localparam logic [CYC_W-1:0]  CYC_HALF     = 13'h0fa0;
  localparam logic [CYC_W-1:0]  LOADER_LEAD  = 13'h0003;
  localparam logic [CYC_W-1:0]  BUS_LEAD     = 13'h0001;
  localparam logic [CYC_W-1:0]  WORKAHEAD    = 13'h0002;
  localparam logic [CYC_W-1:0]  ONE_CYC      = 13'h0001;
  localparam logic [1:0]        PRIME_TOKENS = 2'h2;
  localparam logic [1:0]        LOSS_ROLLS   = 2'h2;
  localparam logic [DROP_W-1:0] DROP_MAX     = 4'hf;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CYC_W-1:0]  SLOT_RST     = 13'h0000;
  localparam logic [DROP_W-1:0] DROP_RST     = 4'h0;
  localparam logic [ADDR_W-1:0] PTR_RST      = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Loader and bus-side states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    D_IDLE  = 9'h001,
    D_PRIME = 9'h002,
    D_GATE  = 9'h004,
    D_MATCH = 9'h008,
    D_MWAIT = 9'h010,
    D_LOAD  = 9'h020,
    D_SKIP  = 9'h040,
    D_NEXT  = 9'h080,
    D_EOC   = 9'h100
  } itw_dstate_t;

  typedef enum logic [4:0] {
    L_IDLE = 5'h01,
    L_WAIT = 5'h02,
    L_HEAD = 5'h04,
    L_ARB  = 5'h08,
    L_TX   = 5'h10
  } itw_lstate_t;

endpackage

// ==== tb/iso_tx_workahead_sync_tb.sv ====
// Purpose: Self-checking bench for the isochronous transmit workahead sync.
// Assumes: Far side is modelled by itw_far_model; cycle number stays at 100.
// Notes:   Inputs change at the falling edge; monitor counts outputs at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module iso_tx_workahead_sync_tb;
  import itw_pkg::*;
  localparam int PL = 3;
  logic core_clk_i, rstn_i, start_i, fast_loss_en_i, cyc_start_i, timer_roll_i, clk_en_i;
  logic subaction_gap_i, iso_period_i, arb_won_i, ptr_load_i, cm_req_o, cm_done_i;
  logic desc_req_o, desc_ack_i, pkt_req_o, pkt_ready_o, pkt_valid_i, pkt_last_i;
  logic fifo_wr_o, fifo_tok_o, fifo_full_i, fifo_empty_i, fifo_tok_head_i, fifo_pop_o;
  logic tx_go_o, tx_done_i, loss_o;
  logic [CYC_W-1:0]  cycle_num_i, cyc_start_num_i, cm_cycle_o, cyc0;
  logic [CTX_W-1:0]  ptr_load_ctx_i, cm_ctx_o;
  logic [ADDR_W-1:0] ptr_load_val_i, cm_ptr_o, desc_skip_i, ptr0;
  logic [DATA_W-1:0] pkt_data_i, fifo_data_o;
  logic [DROP_W-1:0] drops_o, dmax;
  int miscompares, compares, ntok, nwd, ncm, nloss, npop, ndesc, ntx;

  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  itw_sync i_itw_sync (.core_clk_i, .rstn_i, .clk_en_i, .start_i, .fast_loss_en_i,
    .cycle_num_i, .cyc_start_i, .cyc_start_num_i, .timer_roll_i, .subaction_gap_i,
    .iso_period_i, .arb_won_i, .ptr_load_i, .ptr_load_ctx_i, .ptr_load_val_i, .cm_req_o,
    .cm_ctx_o, .cm_cycle_o, .cm_ptr_o, .cm_done_i, .cm_active_i(1'b1), .cm_empty_i(1'b0),
    .desc_req_o, .desc_ack_i, .desc_skip_i, .pkt_req_o, .pkt_ready_o, .pkt_valid_i,
    .pkt_data_i, .pkt_last_i, .pkt_next_ptr_i(32'h0000_2000), .fifo_wr_o, .fifo_data_o,
    .fifo_tok_o, .fifo_full_i, .fifo_empty_i, .fifo_tok_head_i, .fifo_pop_o, .tx_go_o,
    .tx_done_i, .loss_o, .drops_o);

  itw_far_model #(.PKT_LEN(PL)) i_itw_far_model (.core_clk_i, .rstn_i, .cm_req_i(cm_req_o),
    .desc_req_i(desc_req_o), .pkt_req_i(pkt_req_o), .pkt_ready_i(pkt_ready_o),
    .fifo_wr_i(fifo_wr_o), .fifo_tok_i(fifo_tok_o), .fifo_pop_i(fifo_pop_o),
    .tx_go_i(tx_go_o), .cm_done_o(cm_done_i), .desc_ack_o(desc_ack_i),
    .desc_skip_o(desc_skip_i), .pkt_valid_o(pkt_valid_i), .pkt_data_o(pkt_data_i),
    .pkt_last_o(pkt_last_i), .fifo_full_o(fifo_full_i), .fifo_empty_o(fifo_empty_i),
    .fifo_tok_head_o(fifo_tok_head_i), .tx_done_o(tx_done_i));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic wait_cnt(ref int cnt, input int tgt);
    for (int i = 0; i < 3000 && cnt < tgt; i++) @(negedge core_clk_i);
    if (cnt < tgt) begin
      miscompares++;
      $display("unexpected wait: expected %0d seen %0d", tgt, cnt);
      close_out();
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge core_clk_i);
    s = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Output monitor
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (rstn_i) begin
      if (fifo_wr_o && fifo_tok_o) ntok++;
      if (fifo_wr_o && !fifo_tok_o) begin
        check("fifo word", fifo_data_o, nwd);
        nwd++;
      end
      if (cm_req_o) begin
        check("context", 32'(cm_ctx_o), ncm % NCTX);
        if (cm_ctx_o == '0) {cyc0, ptr0} = {cm_cycle_o, cm_ptr_o};
        ncm++;
      end
      if (loss_o) nloss++;
      if (fifo_pop_o) npop++;
      if (desc_req_o) ndesc++;
      if (tx_go_o) ntx++;
      if (drops_o > dmax) dmax = drops_o;
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_start;
    for (int i = 0; i < NCTX; i++) begin
      ptr_load_ctx_i = CTX_W'(i);
      ptr_load_val_i = 32'h0000_1000 + 32'(i);
      ptr_load_i = 1'b1;
      @(negedge core_clk_i);
    end
    ptr_load_i = 1'b0;
    cyc_start_num_i = 13'h0064;
    pulse(cyc_start_i);
    clk_en_i = 1'b0;
    pulse(start_i);
    repeat (8) @(negedge core_clk_i);
    check("frozen start", ntok + npop, 0);
    clk_en_i = 1'b1;
    pulse(start_i);
    repeat (40) @(negedge core_clk_i);
    check("prime tokens", ntok, 2);
    check("early passes", ncm, 0);
    check("early pops", npop, 0);
  endtask

  task automatic t_pass;
    cyc_start_num_i = 13'h0065;
    pulse(cyc_start_i);
    wait_cnt(ntok, 3);
    check("pass cycle", cyc0, 13'h0067);
    check("ctx0 pointer", ptr0, 32'h0000_1000);
    check("words", nwd, NCTX * PL);
    check("pops", npop, 1);
    repeat (40) @(negedge core_clk_i);
    check("gated passes", ncm, 4);
  endtask

  task automatic t_loss;
    pulse(timer_roll_i);
    repeat (3) @(negedge core_clk_i);
    pulse(timer_roll_i);
    wait_cnt(ncm, 8);
    check("losses", nloss, 1);
    check("peak drops", 32'(dmax), 1);
    check("skip cycle", cyc0, 13'h0068);
    wait_cnt(ndesc, 4);
    repeat (10) @(negedge core_clk_i);
    check("skip writes", ntok + nwd, 3 + NCTX * PL);
    check("drops left", 32'(drops_o), 0);
  endtask

  task automatic t_fast;
    fast_loss_en_i = 1'b1;
    cyc_start_num_i = 13'h0067;
    pulse(cyc_start_i);
    wait_cnt(ntok, 4);
    check("ptr after skip", ptr0, 32'h0000_5a00);
    check("pops", npop, 2);
    pulse(timer_roll_i);
    pulse(subaction_gap_i);
    wait_cnt(nloss, 2);
    wait_cnt(ncm, 16);
  endtask

  task automatic t_tx;
    cyc_start_num_i = 13'h0069;
    arb_won_i = 1'b1;
    pulse(cyc_start_i);
    wait_cnt(npop, 3);
    arb_won_i = 1'b0;
    check("packets sent", ntx, 4);
    check("losses", nloss, 2);
  endtask

  initial begin
    {rstn_i, start_i, fast_loss_en_i, cyc_start_i, timer_roll_i, subaction_gap_i} = '0;
    {arb_won_i, ptr_load_i, ptr_load_ctx_i, ptr_load_val_i, cyc_start_num_i, dmax} = '0;
    {iso_period_i, clk_en_i} = 2'h3;
    cycle_num_i = 13'h0064;
    repeat (16) @(negedge core_clk_i);
    rstn_i = 1'b1;
    t_start();
    t_pass();
    t_loss();
    t_fast();
    t_tx();
    close_out();
  end
endmodule
`default_nettype wire

// ==== tb/itw_far_model.sv ====
// Purpose: Far-side model: context memory, packet source, transmit FIFO and transmitter.
// Assumes: Every packet is PKT_LEN words; every context is active.
// Notes:   Cycle match answers after two cycles, descriptor reads after one.
`timescale 1ns/1ps
`default_nettype none
module itw_far_model #(
  parameter int          PKT_LEN  = 3,
  parameter int          DEPTH    = 64,
  parameter logic [31:0] SKIP_PTR = 32'h0000_5a00
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // Requests from the block
  input  wire logic        cm_req_i,
  input  wire logic        desc_req_i,
  input  wire logic        pkt_req_i,
  input  wire logic        pkt_ready_i,
  input  wire logic        fifo_wr_i,
  input  wire logic        fifo_tok_i,
  input  wire logic        fifo_pop_i,
  input  wire logic        tx_go_i,
  // Answers
  output logic             cm_done_o,
  output logic             desc_ack_o,
  output logic [31:0]      desc_skip_o,
  output logic             pkt_valid_o,
  output logic [31:0]      pkt_data_o,
  output logic             pkt_last_o,
  output logic             fifo_full_o,
  output logic             fifo_empty_o,
  output logic             fifo_tok_head_o,
  output logic             tx_done_o
);
  logic q[$];
  int   left;
  int   seq;
  logic cm_d;
  logic tx_d;
  always @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q = {};
      left = 0;
      seq = 0;
      {cm_d, tx_d, cm_done_o, desc_ack_o, pkt_valid_o, pkt_last_o} <= '0;
      {fifo_full_o, fifo_tok_head_o, tx_done_o, desc_skip_o, pkt_data_o} <= '0;
      fifo_empty_o <= 1'b1;
    end else begin
      cm_d <= cm_req_i;
      cm_done_o <= cm_d;
      desc_ack_o <= desc_req_i;
      desc_skip_o <= desc_req_i ? SKIP_PTR : ~desc_skip_o;
      if (pkt_valid_o && pkt_ready_i) begin
        seq++;
        left--;
      end
      if (pkt_req_i) left = PKT_LEN;
      pkt_valid_o <= (left != 0);
      pkt_data_o <= (left != 0) ? 32'(seq) : ~32'(seq);
      pkt_last_o <= (left == 1);
      if (fifo_wr_i) q.push_back(fifo_tok_i);
      if (fifo_pop_i && q.size() != 0) void'(q.pop_front());
      // Transmitter drains one packet, then reports done
      tx_d <= tx_go_i;
      tx_done_o <= tx_d;
      if (tx_d) begin
        for (int i = 0; i < PKT_LEN && q.size() != 0; i++) void'(q.pop_front());
      end
      fifo_empty_o <= (q.size() == 0);
      fifo_tok_head_o <= (q.size() != 0) && q[0];
      fifo_full_o <= (q.size() >= DEPTH - 1);
    end
  end
endmodule
`default_nettype wire
